// ==== design/telegram_device.sv ====
// drive-side telegram configuration, layout build and cyclic data path
//
// Behaviour
// - type codes 1,3,4 standard, 7 application
// - controller writes type only in phase 2
// - no configured layout means no cyclic data
// - type 1: 2-byte torque out, nothing back
// - type 3: 4-byte velocity out, position back
// - type 4: 4-byte position out, position back
// - application lists for both directions independent
// - controller writes allowed out-list ids in phase 2
// - back list takes only allowed ids, 0..4
// - read-only max length per direction
// - phase-3 check builds layout from the type code, with the list counts for type 7
// - cyclic data used only in phase 4
// - at most four ids per telegram
// - type 7 takes its word counts from the application lists
// - up to 64 bytes per direction
`timescale 1ns/100ps
module telegram_device
  import telegram_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                mclk,
  input  wire logic                rstn,
  telegram_if.dev                  bus,
  output logic                     out_valid,
  output logic [1:0]               out_slot,
  output logic [DW-1:0]            out_data,
  input  wire logic                out_ready,
  input  wire logic [NSLOT*DW-1:0] act_values,
  output logic                     cyc_active
);
  typedef enum logic [1:0] {AT_IDLE = 2'b00, AT_SEND = 2'b01} at_state_t;

  logic [15:0] tel_type;
  logic [15:0] mdt_list [NSLOT];
  logic [15:0] at_list [NSLOT];
  logic [2:0]  mdt_cnt;
  logic [2:0]  at_cnt;
  logic [2:0]  lay_mdt_n;
  logic [2:0]  lay_at_n;
  logic        lay_narrow;
  logic        built;
  logic [2:0]  mdt_slot;
  logic [2:0]  at_idx;
  at_state_t   at_state;
  logic [2:0]  next_mdt_n;
  logic [2:0]  next_at_n;
  logic        next_narrow;
  logic [15:0] rd_val;
  logic        rd_known;
  logic        fifo_in_ready;
  logic [DW+1:0] fifo_out;

  function automatic logic [DW-1:0] act_word(input logic [2:0] i);
    return act_values[i[1:0]*DW +: DW];
  endfunction

  // service channel decode; every write outside phase 2 is refused
  wire logic in_cfg   = bus.phase == PH_CFG;
  wire logic wr_type  = bus.svc_wr && bus.svc_param == PAR_TYPE;
  wire logic wr_mlist = bus.svc_wr && bus.svc_param == PAR_MDT_LIST;
  wire logic wr_alist = bus.svc_wr && bus.svc_param == PAR_AT_LIST;
  wire logic wr_mcnt  = bus.svc_wr && bus.svc_param == PAR_MDT_CNT;
  wire logic wr_acnt  = bus.svc_wr && bus.svc_param == PAR_AT_CNT;
  wire logic cnt_ok   = bus.svc_wdata <= {13'h0000, MAX_IDS};
  wire logic wr_good  = in_cfg && (
      (wr_type && type_ok(bus.svc_wdata)) ||
      (wr_mlist && mdt_id_ok(bus.svc_wdata)) ||
      (wr_alist && at_id_ok(bus.svc_wdata)) ||
      ((wr_mcnt || wr_acnt) && cnt_ok));

  // readable parameters; lengths are fixed and read-only
  always_comb begin
    rd_val   = 16'h0000;
    rd_known = 1'b1;
    case (bus.svc_param)
      PAR_TYPE:     rd_val = tel_type;
      PAR_MDT_LIST: rd_val = mdt_list[bus.svc_idx];
      PAR_AT_LIST:  rd_val = at_list[bus.svc_idx];
      PAR_MDT_CNT:  rd_val = {13'h0000, mdt_cnt};
      PAR_AT_CNT:   rd_val = {13'h0000, at_cnt};
      PAR_MDT_LEN:  rd_val = MAX_REC_BYTES;
      PAR_AT_LEN:   rd_val = MAX_REC_BYTES;
      PAR_LAYOUT:   rd_val = {8'h00, built, lay_narrow, lay_at_n, lay_mdt_n};
      default:      rd_known = 1'b0;
    endcase
  end

  // service answer one cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus.svc_ack   <= 1'b0;
      bus.svc_err   <= 1'b0;
      bus.svc_rdata <= 16'h0000;
    end else begin
      bus.svc_ack   <= bus.svc_wr || bus.svc_rd;
      bus.svc_err   <= (bus.svc_wr && !wr_good) || (bus.svc_rd && !rd_known);
      bus.svc_rdata <= bus.svc_rd ? rd_val : 16'h0000;
    end
  end

  // configuration storage; the two lists never constrain each other
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tel_type <= TYPE_RESET;
      mdt_cnt  <= 3'h0;
      at_cnt   <= 3'h0;
      for (int i = 0; i < NSLOT; i++) begin
        mdt_list[i] <= 16'h0000;
        at_list[i]  <= 16'h0000;
      end
    end else if (wr_good) begin
      if (wr_type) tel_type <= bus.svc_wdata;
      if (wr_mlist) mdt_list[bus.svc_idx] <= bus.svc_wdata;
      if (wr_alist) at_list[bus.svc_idx] <= bus.svc_wdata;
      if (wr_mcnt) mdt_cnt <= bus.svc_wdata[2:0];
      if (wr_acnt) at_cnt <= bus.svc_wdata[2:0];
    end
  end

  // layout chosen by the type selector
  always_comb begin
    next_mdt_n  = 3'h0;
    next_at_n   = 3'h0;
    next_narrow = 1'b0;
    case (tel_type[2:0])
      TT_STD1: begin
        next_mdt_n  = 3'h1;
        next_narrow = 1'b1;
      end
      TT_STD3: begin
        next_mdt_n = 3'h1;
        next_at_n  = 3'h1;
      end
      TT_STD4: begin
        next_mdt_n = 3'h1;
        next_at_n  = 3'h1;
      end
      TT_APP: begin
        next_mdt_n = mdt_cnt;
        next_at_n  = at_cnt;
      end
      default: next_mdt_n = 3'h0;
    endcase
  end

  // built in the phase-3 check, dropped on return to phase 2
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lay_mdt_n  <= 3'h0;
      lay_at_n   <= 3'h0;
      lay_narrow <= 1'b0;
      built      <= 1'b0;
    end else if (bus.build && bus.phase == PH_CHECK) begin
      lay_mdt_n  <= next_mdt_n;
      lay_at_n   <= next_at_n;
      lay_narrow <= next_narrow;
      built      <= 1'b1;
    end else if (in_cfg) begin
      built <= 1'b0;
    end
  end

  // out-bound words are kept only in phase 4 and within the layout
  wire logic run    = built && bus.phase == PH_RUN;
  wire logic keep   = run && mdt_slot < lay_mdt_n;
  wire logic accept = bus.mdt_valid && bus.mdt_ready;
  wire logic [DW-1:0] mdt_word = lay_narrow ?
                                 {16'h0000, bus.mdt_data[15:0] & NARROW_MASK} :
                                 bus.mdt_data;
  assign bus.mdt_ready = !keep || fifo_in_ready;

  word_fifo #(.W(DW + 2), .DEPTH(DEPTH)) word_fifo_i (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (bus.mdt_valid && keep),
    .in_ready  (fifo_in_ready),
    .in_data   ({mdt_slot[1:0], mdt_word}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );
  assign out_slot = fifo_out[DW+1:DW];
  assign out_data = fifo_out[DW-1:0];

  wire logic start_at = accept && bus.mdt_last && run && lay_at_n != 3'h0 && at_state == AT_IDLE;
  wire logic at_take  = bus.at_valid && bus.at_ready;

  // slot counter saturates so a long telegram cannot wrap into slot 0
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mdt_slot   <= 3'h0;
      cyc_active <= 1'b0;
    end else begin
      cyc_active <= run;
      if (accept && bus.mdt_last) mdt_slot <= 3'h0;
      else if (accept && mdt_slot != MAX_IDS) mdt_slot <= mdt_slot + 3'h1;
    end
  end

  // answer telegram follows the last accepted out-bound word
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      at_state     <= AT_IDLE;
      at_idx       <= 3'h0;
      bus.at_valid <= 1'b0;
      bus.at_data  <= '0;
      bus.at_last  <= 1'b0;
    end else begin
      case (at_state)
        AT_IDLE: begin
          if (start_at) begin
            at_state     <= AT_SEND;
            at_idx       <= 3'h0;
            bus.at_valid <= 1'b1;
            bus.at_data  <= act_word(3'h0);
            bus.at_last  <= lay_at_n == 3'h1;
          end
        end
        AT_SEND: begin
          if (at_take && bus.at_last) begin
            at_state     <= AT_IDLE;
            bus.at_valid <= 1'b0;
            bus.at_last  <= 1'b0;
          end else if (at_take) begin
            at_idx      <= at_idx + 3'h1;
            bus.at_data <= act_word(at_idx + 3'h1);
            bus.at_last <= at_idx + 3'h2 == lay_at_n;
          end
        end
        default: at_state <= AT_IDLE;
      endcase
    end
  end
endmodule

// ==== design/telegram_pkg.sv ====
// shared constants, parameter codes and helpers for the cyclic telegram link
package telegram_pkg;
  localparam int DW      = 32;
  localparam int NSLOT   = 4;
  localparam int FIFO_DEPTH = 16;

  // communication phases driven by the controller
  localparam logic [2:0] PH_CFG   = 3'h2;
  localparam logic [2:0] PH_CHECK = 3'h3;
  localparam logic [2:0] PH_RUN   = 3'h4;

  // telegram type selector codes (bits 2..0)
  localparam logic [2:0] TT_STD1 = 3'h1;
  localparam logic [2:0] TT_STD3 = 3'h3;
  localparam logic [2:0] TT_STD4 = 3'h4;
  localparam logic [2:0] TT_APP  = 3'h7;
  localparam logic [15:0] TYPE_RESET = 16'h0000;

  // service channel parameter codes
  localparam logic [3:0] PAR_TYPE     = 4'h0;
  localparam logic [3:0] PAR_MDT_LIST = 4'h1;
  localparam logic [3:0] PAR_AT_LIST  = 4'h2;
  localparam logic [3:0] PAR_MDT_CNT  = 4'h3;
  localparam logic [3:0] PAR_AT_CNT   = 4'h4;
  localparam logic [3:0] PAR_MDT_LEN  = 4'h5;
  localparam logic [3:0] PAR_AT_LEN   = 4'h6;
  localparam logic [3:0] PAR_LAYOUT   = 4'h7;

  // identifiers of the cyclic values
  localparam logic [15:0] ID_TORQUE_CMD = 16'h0050;
  localparam logic [15:0] ID_VEL_CMD    = 16'h0024;
  localparam logic [15:0] ID_POS_CMD    = 16'h002F;
  localparam logic [15:0] ID_POS_FB     = 16'h0033;
  localparam logic [15:0] ID_VEL_FB     = 16'h0028;
  localparam logic [15:0] ID_TORQUE_FB  = 16'h0054;

  localparam logic [2:0]  MAX_IDS       = 3'h4;
  localparam logic [15:0] MAX_REC_BYTES = 16'h0040;
  localparam logic [15:0] NARROW_MASK   = 16'hFFFF;

  // controller register indices
  localparam logic [3:0] A_CTRL     = 4'h0;
  localparam logic [3:0] A_SVC_CMD  = 4'h1;
  localparam logic [3:0] A_SVC_STAT = 4'h2;
  localparam logic [3:0] A_MDT_N    = 4'h3;
  localparam logic [3:0] A_SEND     = 4'h4;
  localparam logic [3:0] A_SP0      = 4'h5;
  localparam logic [3:0] A_ACT0     = 4'h9;
  localparam logic [3:0] A_AT_N     = 4'hD;
  localparam int CTRL_BUILD_BIT = 8;
  localparam int SVC_RD_BIT     = 8;
  localparam int SVC_DATA_LSB   = 16;

  function automatic logic type_ok(input logic [15:0] v);
    return (v[15:3] == 13'h0000) &&
           (v[2:0] == TT_STD1 || v[2:0] == TT_STD3 || v[2:0] == TT_STD4 || v[2:0] == TT_APP);
  endfunction

  function automatic logic mdt_id_ok(input logic [15:0] v);
    return v == ID_TORQUE_CMD || v == ID_VEL_CMD || v == ID_POS_CMD;
  endfunction

  function automatic logic at_id_ok(input logic [15:0] v);
    return v == ID_POS_FB || v == ID_VEL_FB || v == ID_TORQUE_FB;
  endfunction
endpackage

// ==== design/telegram_if.sv ====
// link between cyclic telegram controller and drive-side telegram logic
`timescale 1ns/100ps
interface telegram_if (
  input wire logic mclk,
  input wire logic rstn
);
  logic [2:0]  phase;
  logic        build;
  logic        svc_wr;
  logic        svc_rd;
  logic [3:0]  svc_param;
  logic [1:0]  svc_idx;
  logic [15:0] svc_wdata;
  logic        svc_ack;
  logic        svc_err;
  logic [15:0] svc_rdata;
  logic        mdt_valid;
  logic        mdt_ready;
  logic [31:0] mdt_data;
  logic        mdt_last;
  logic        at_valid;
  logic        at_ready;
  logic [31:0] at_data;
  logic        at_last;

  modport dev (
    input  phase, build, svc_wr, svc_rd, svc_param, svc_idx, svc_wdata,
    input  mdt_valid, mdt_data, mdt_last, at_ready,
    output svc_ack, svc_err, svc_rdata, mdt_ready, at_valid, at_data, at_last
  );
  modport mst (
    output phase, build, svc_wr, svc_rd, svc_param, svc_idx, svc_wdata,
    output mdt_valid, mdt_data, mdt_last, at_ready,
    input  svc_ack, svc_err, svc_rdata, mdt_ready, at_valid, at_data, at_last
  );
endinterface

// ==== design/word_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
  parameter int W     = 34,
  parameter int DEPTH = 16
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   count;
  wire logic push = in_valid && in_ready;
  wire logic pop  = out_valid && out_ready;

  // full and empty straight from the occupancy count
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rptr];

  always_ff @(posedge mclk) begin
    if (push) mem[wptr] <= in_data;
  end

  // pointers wrap naturally because depth is a power of two
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== design/telegram_master.sv ====
// controller end: service channel, phase control, cyclic out/back telegrams
`timescale 1ns/100ps
module telegram_master
  import telegram_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  telegram_if.mst          bus,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_MDT = 2'b01, M_AT = 2'b10} m_state_t;

  m_state_t    st;
  logic [31:0] sp [NSLOT];
  logic [31:0] act [NSLOT];
  logic [2:0]  mdt_n;
  logic [2:0]  at_n;
  logic [2:0]  slot;
  logic [2:0]  at_got;
  logic        svc_busy;
  logic        svc_fail;
  logic [15:0] svc_val;
  logic [31:0] rd_mux;

  wire logic w_ctrl = wr && addr == A_CTRL;
  wire logic w_svc  = wr && addr == A_SVC_CMD && !svc_busy;
  wire logic w_send = wr && addr == A_SEND && st == M_IDLE && mdt_n != 3'h0;
  wire logic w_sp   = wr && addr >= A_SP0 && addr < A_ACT0;
  wire logic [1:0] sp_i  = 2'(addr - A_SP0);
  wire logic [1:0] act_i = 2'(addr - A_ACT0);
  assign bus.at_ready = st == M_AT;

  // register read selection
  assign rd_mux = addr == A_CTRL     ? {29'h0, bus.phase} :
                  addr == A_SVC_STAT ? {svc_val, 14'h0, svc_fail, svc_busy} :
                  addr == A_MDT_N    ? {29'h0, mdt_n} :
                  addr == A_SEND     ? {31'h0, st != M_IDLE} :
                  addr == A_AT_N     ? {26'h0, at_got, at_n} :
                  (addr >= A_SP0 && addr < A_ACT0) ? sp[sp_i] :
                  (addr >= A_ACT0 && addr < A_AT_N) ? act[act_i] : 32'h0;

  // software registers; read data appear one cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata     <= 32'h0;
      bus.phase <= 3'h0;
      bus.build <= 1'b0;
      mdt_n     <= 3'h0;
      at_n      <= 3'h0;
      for (int i = 0; i < NSLOT; i++) sp[i] <= 32'h0;
    end else begin
      rdata     <= rd ? rd_mux : 32'h0;
      bus.build <= w_ctrl && wdata[CTRL_BUILD_BIT];
      if (w_ctrl) bus.phase <= wdata[2:0];
      if (wr && addr == A_MDT_N) mdt_n <= wdata[2:0];
      if (wr && addr == A_AT_N) at_n <= wdata[2:0];
      if (w_sp) sp[sp_i] <= wdata;
    end
  end

  // one service request at a time; commands while busy are dropped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus.svc_wr    <= 1'b0;
      bus.svc_rd    <= 1'b0;
      bus.svc_param <= 4'h0;
      bus.svc_idx   <= 2'h0;
      bus.svc_wdata <= 16'h0000;
      svc_busy      <= 1'b0;
      svc_fail      <= 1'b0;
      svc_val       <= 16'h0000;
    end else begin
      bus.svc_wr <= w_svc && !wdata[SVC_RD_BIT];
      bus.svc_rd <= w_svc && wdata[SVC_RD_BIT];
      if (w_svc) begin
        bus.svc_param <= wdata[3:0];
        bus.svc_idx   <= wdata[5:4];
        bus.svc_wdata <= wdata[SVC_DATA_LSB +: 16];
        svc_busy      <= 1'b1;
      end else if (bus.svc_ack) begin
        svc_busy <= 1'b0;
        svc_fail <= bus.svc_err;
        svc_val  <= bus.svc_rdata;
      end
    end
  end

  // cyclic exchange: send setpoints, then collect the answer words
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st            <= M_IDLE;
      slot          <= 3'h0;
      at_got        <= 3'h0;
      bus.mdt_valid <= 1'b0;
      bus.mdt_data  <= 32'h0;
      bus.mdt_last  <= 1'b0;
      for (int i = 0; i < NSLOT; i++) act[i] <= 32'h0;
    end else begin
      case (st)
        M_IDLE: begin
          if (w_send) begin
            st            <= M_MDT;
            slot          <= 3'h0;
            at_got        <= 3'h0;
            bus.mdt_valid <= 1'b1;
            bus.mdt_data  <= sp[0];
            bus.mdt_last  <= mdt_n == 3'h1;
          end
        end
        M_MDT: begin
          if (bus.mdt_ready && bus.mdt_last) begin
            st            <= at_n == 3'h0 ? M_IDLE : M_AT;
            bus.mdt_valid <= 1'b0;
            bus.mdt_last  <= 1'b0;
          end else if (bus.mdt_ready) begin
            slot         <= slot + 3'h1;
            bus.mdt_data <= sp[2'(slot + 3'h1)];
            bus.mdt_last <= slot + 3'h2 == mdt_n;
          end
        end
        M_AT: begin
          if (bus.at_valid) begin
            act[at_got[1:0]] <= bus.at_data;
            at_got           <= at_got + 3'h1;
            if (bus.at_last) st <= M_IDLE;
          end
        end
        default: st <= M_IDLE;
      endcase
    end
  end
endmodule

// ==== verif/telegram_link_properties.sv ====
// concurrent checks on the link between controller and drive-side telegram logic
`timescale 1ns/100ps
module telegram_link_properties
  import telegram_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [2:0]  phase,
  input wire logic        svc_wr,
  input wire logic        svc_rd,
  input wire logic [3:0]  svc_param,
  input wire logic [15:0] svc_wdata,
  input wire logic        svc_ack,
  input wire logic        svc_err,
  input wire logic [15:0] svc_rdata,
  input wire logic        mdt_valid,
  input wire logic        mdt_ready,
  input wire logic        mdt_last,
  input wire logic        at_valid,
  input wire logic        at_ready,
  input wire logic [31:0] at_data,
  input wire logic        at_last
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // decodes of the service command, kept apart so properties stay readable
  wire logic wr_type  = svc_wr && svc_param == PAR_TYPE;
  wire logic bad_code = svc_wdata[15:3] != 13'h0000 ||
                        !(svc_wdata[2:0] inside {3'h1, 3'h3, 3'h4, 3'h7});
  wire logic wr_cnt   = svc_wr && (svc_param == PAR_MDT_CNT || svc_param == PAR_AT_CNT);
  wire logic bad_at   = !(svc_wdata inside {ID_POS_FB, ID_VEL_FB, ID_TORQUE_FB});
  wire logic rd_len   = svc_rd && (svc_param == PAR_MDT_LEN || svc_param == PAR_AT_LEN);

  a_ack_follows_cmd: assert property ((svc_wr || svc_rd) |=> svc_ack)
    else $error("service ack missing");
  a_ack_has_cause: assert property (svc_ack |-> $past(svc_wr || svc_rd))
    else $error("service ack without command");
  a_type_code_bad: assert property (wr_type && bad_code |=> svc_err)
    else $error("bad type code accepted");
  a_type_code_good: assert property (
    wr_type && !bad_code && phase == PH_CFG |=> !svc_err)
    else $error("good type code refused");
  a_write_outside_cfg: assert property (svc_wr && phase != PH_CFG |=> svc_err)
    else $error("write outside config phase accepted");
  a_count_over_four: assert property (wr_cnt && svc_wdata > 16'h0004 |=> svc_err)
    else $error("count above four accepted");
  a_back_list_ids: assert property (
    svc_wr && svc_param == PAR_AT_LIST && bad_at |=> svc_err)
    else $error("foreign id in back list accepted");
  a_length_report: assert property (rd_len |=> svc_rdata == MAX_REC_BYTES && !svc_err)
    else $error("record length wrong");
  a_back_only_run: assert property ($rose(at_valid) |->
    phase == PH_RUN && $past(mdt_valid && mdt_ready && mdt_last))
    else $error("back telegram out of turn");
  a_back_word_holds: assert property (at_valid && !at_ready |=>
    at_valid && $stable(at_data) && $stable(at_last))
    else $error("back word changed while waiting");
endmodule

// ==== verif/test_cyclic_telegram_config.sv ====
// self-checking bench: controller and drive-side telegram logic face to face
`timescale 1ns/100ps
module test_cyclic_telegram_config
  import telegram_pkg::*;
;
  logic                mclk;
  logic                rstn;
  logic [3:0]          addr;
  logic [31:0]         wdata;
  logic [31:0]         rdata;
  logic                wr;
  logic                rd;
  logic                out_valid;
  logic                out_ready;
  logic [1:0]          out_slot;
  logic [DW-1:0]       out_data;
  logic [NSLOT*DW-1:0] act_values;
  logic                cyc_active;
  int                  err_count;
  int                  n_compared;

  telegram_if telegram_if_i (.mclk(mclk), .rstn(rstn));
  telegram_device telegram_device_i (.mclk(mclk), .rstn(rstn), .bus(telegram_if_i),
    .out_valid(out_valid), .out_slot(out_slot), .out_data(out_data), .out_ready(out_ready),
    .act_values(act_values), .cyc_active(cyc_active));
  telegram_master telegram_master_i (.mclk(mclk), .rstn(rstn), .bus(telegram_if_i),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  telegram_link_properties telegram_link_properties_i (.mclk(mclk), .rstn(rstn),
    .phase(telegram_if_i.phase), .svc_wr(telegram_if_i.svc_wr),
    .svc_rd(telegram_if_i.svc_rd), .svc_param(telegram_if_i.svc_param),
    .svc_wdata(telegram_if_i.svc_wdata), .svc_ack(telegram_if_i.svc_ack),
    .svc_err(telegram_if_i.svc_err), .svc_rdata(telegram_if_i.svc_rdata),
    .mdt_valid(telegram_if_i.mdt_valid), .mdt_ready(telegram_if_i.mdt_ready),
    .mdt_last(telegram_if_i.mdt_last), .at_valid(telegram_if_i.at_valid),
    .at_ready(telegram_if_i.at_ready), .at_data(telegram_if_i.at_data),
    .at_last(telegram_if_i.at_last));

  // verdict and run end, reached from the main sequence and from any timeout
  task automatic conclude;
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up;
    err_count++;
    $display("ERROR wait expected done seen hang");
    conclude();
  endtask

  // register port: one-cycle strobes, read data the cycle after the read edge
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic set_phase(input logic [2:0] ph, input logic bld);
    wr_reg(A_CTRL, {23'h0, bld, 5'h00, ph});
  endtask

  // service command, polled to completion, then error flag and read value judged
  task automatic svc(input logic [3:0] par, input logic [1:0] idx, input logic [15:0] d,
                     input logic is_rd, input logic exp_err, input logic [15:0] exp_val);
    logic [31:0] st;
    wr_reg(A_SVC_CMD, {d, 7'h00, is_rd, 2'b00, idx, par});
    for (int n = 0; n < 20; n++) begin
      rd_reg(A_SVC_STAT, st);
      if (st[0] === 1'b0) break;
      if (n == 19) give_up();
    end
    chk("svc error", 32'(exp_err), 32'(st[1]));
    if (is_rd && !exp_err) chk("svc value", 32'(exp_val), 32'(st[31:16]));
  endtask

  task automatic wait_send;
    logic [31:0] v;
    for (int n = 0; n < 80; n++) begin
      rd_reg(A_SEND, v);
      if (v[0] === 1'b0) return;
    end
    give_up();
  endtask

  // take one word from the out fifo; ready pulses for exactly one edge
  task automatic pop(input logic [1:0] s, input logic [31:0] d);
    int n = 0;
    while (out_valid !== 1'b1) begin
      @(posedge mclk);
      #1 n++;
      if (n > 40) give_up();
    end
    chk("out slot", 32'(s), 32'(out_slot));
    chk("out data", d, out_data);
    @(posedge mclk);
    out_ready <= 1'b1;
    @(posedge mclk);
    out_ready <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    chk("cyc_active", 32'h0, 32'(cyc_active));
    svc(PAR_TYPE, 2'h0, 16'h0000, 1'b1, 1'b0, TYPE_RESET);
    svc(PAR_LAYOUT, 2'h0, 16'h0000, 1'b1, 1'b0, 16'h0000);
    svc(PAR_MDT_LEN, 2'h0, 16'h0000, 1'b1, 1'b0, MAX_REC_BYTES);
    svc(PAR_AT_LEN, 2'h0, 16'h0000, 1'b1, 1'b0, MAX_REC_BYTES);
    set_phase(PH_CFG, 1'b0);
    svc(PAR_AT_LEN, 2'h0, 16'h0010, 1'b0, 1'b1, 16'h0000);
  endtask

  task automatic t_types;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      svc(PAR_TYPE, 2'h0, {13'h0, c}, 1'b0, !(c == 3'h1 || c == 3'h3 || c == 3'h4 || c == 3'h7),
          16'h0000);
    end
    svc(PAR_TYPE, 2'h0, 16'h000C, 1'b0, 1'b1, 16'h0000);
    set_phase(PH_RUN, 1'b0);
    svc(PAR_TYPE, 2'h0, 16'h0001, 1'b0, 1'b1, 16'h0000);
    svc(PAR_MDT_LIST, 2'h0, ID_POS_CMD, 1'b0, 1'b1, 16'h0000);
    svc(PAR_TYPE, 2'h0, 16'h0000, 1'b1, 1'b0, 16'h0007);
  endtask

  // each standard layout: one word out (second slot dropped), back word per layout
  task automatic t_standard;
    logic [31:0] v;
    logic [2:0]  codes [3] = '{3'h1, 3'h3, 3'h4};
    logic [2:0]  at_n;
    for (int k = 0; k < 3; k++) begin
      at_n = (k == 0) ? 3'h0 : 3'h1;
      set_phase(PH_CFG, 1'b0);
      svc(PAR_TYPE, 2'h0, {13'h0, codes[k]}, 1'b0, 1'b0, 16'h0000);
      set_phase(PH_CHECK, 1'b1);
      svc(PAR_LAYOUT, 2'h0, 16'h0000, 1'b1, 1'b0,
          {8'h00, 1'b1, k == 0, at_n, 3'h1});
      set_phase(PH_RUN, 1'b0);
      act_values <= {96'h0, 32'hA5C30F10 + 32'(k)};
      wr_reg(A_SP0, 32'h87654321);
      wr_reg(A_MDT_N, 32'h2);
      wr_reg(A_AT_N, 32'(at_n));
      wr_reg(A_SEND, 32'h1);
      wait_send();
      pop(2'h0, (k == 0) ? 32'h00004321 : 32'h87654321);
      chk("fifo empty", 32'h0, 32'(out_valid));
      chk("cyc_active", 32'h1, 32'(cyc_active));
      rd_reg(A_AT_N, v);
      chk("back count", 32'(at_n), 32'(v[5:3]));
      rd_reg(A_ACT0, v);
      if (k > 0) chk("back value", 32'hA5C30F10 + 32'(k), v);
    end
  endtask

  // application lists, words sent outside run dropped, then fill the fifo and drain it
  task automatic t_app;
    logic [31:0] v;
    logic [15:0] mid [4] = '{ID_TORQUE_CMD, ID_VEL_CMD, ID_POS_CMD, ID_VEL_CMD};
    set_phase(PH_CFG, 1'b0);
    svc(PAR_TYPE, 2'h0, 16'h0007, 1'b0, 1'b0, 16'h0000);
    svc(PAR_MDT_LIST, 2'h0, ID_POS_FB, 1'b0, 1'b1, 16'h0000);
    for (int i = 0; i < 4; i++) svc(PAR_MDT_LIST, 2'(i), mid[i], 1'b0, 1'b0, 16'h0);
    svc(PAR_AT_LIST, 2'h0, ID_POS_FB, 1'b0, 1'b0, 16'h0000);
    svc(PAR_AT_LIST, 2'h1, ID_VEL_FB, 1'b0, 1'b0, 16'h0000);
    svc(PAR_AT_LIST, 2'h2, ID_POS_CMD, 1'b0, 1'b1, 16'h0000);
    svc(PAR_MDT_CNT, 2'h0, 16'h0005, 1'b0, 1'b1, 16'h0000);
    svc(PAR_AT_CNT, 2'h0, 16'h0005, 1'b0, 1'b1, 16'h0000);
    svc(PAR_MDT_CNT, 2'h0, 16'h0004, 1'b0, 1'b0, 16'h0000);
    svc(PAR_AT_CNT, 2'h0, 16'h0002, 1'b0, 1'b0, 16'h0000);
    svc(PAR_AT_LIST, 2'h1, 16'h0000, 1'b1, 1'b0, ID_VEL_FB);
    set_phase(PH_CHECK, 1'b1);
    svc(PAR_LAYOUT, 2'h0, 16'h0000, 1'b1, 1'b0, 16'h0094);
    act_values <= {64'h0, 32'hBEEF0002, 32'hBEEF0001};
    for (int i = 0; i < 4; i++) wr_reg(A_SP0 + 4'(i), 32'h11111111 * 32'(i + 1));
    wr_reg(A_MDT_N, 32'h4);
    wr_reg(A_AT_N, 32'h0);
    wr_reg(A_SEND, 32'h1);
    wait_send();
    repeat (4) @(posedge mclk);
    chk("no data in check", 32'h0, 32'(out_valid));
    set_phase(PH_RUN, 1'b0);
    for (int t = 0; t < 5; t++) begin
      wr_reg(A_SEND, 32'h1);
      if (t < 4) wait_send();
      wr_reg(A_AT_N, 32'h2); // fifth send left waiting on the full fifo
    end
    repeat (10) @(posedge mclk);
    chk("out stall", 32'h0, 32'(telegram_if_i.mdt_ready));
    for (int j = 0; j < 20; j++) pop(2'(j % 4), 32'h11111111 * 32'(j % 4 + 1));
    wait_send();
    rd_reg(A_ACT0, v);
    chk("back slot 0", 32'hBEEF0001, v);
    rd_reg(A_ACT0 + 4'h1, v);
    chk("back slot 1", 32'hBEEF0002, v);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // main sequence: reset for three cycles, then the scenarios in turn
  initial begin
    rstn       = 1'b0;
    wr         = 1'b0;
    rd         = 1'b0;
    addr       = 4'h0;
    wdata      = 32'h0;
    out_ready  = 1'b0;
    act_values = '0;
    err_count  = 0;
    n_compared = 0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_types();
    t_standard();
    t_app();
    conclude();
  end
endmodule
